/* File: shared/sadc_pkg.sv */
// Purpose: shared constants for the converter link, both ends and the fifo
// Assumes: 100 MHz system clock on both ends
// Notes:   counts derived from times; long counts become top-level parameters
package sadc_pkg;
  // result word
  localparam int             RESULT_W      = 18;
  localparam logic [4:0]     MSB_POS       = 5'(RESULT_W - 1);
  localparam logic [17:0]    PAT_SINGLE    = 18'h281FC;  // one-lane test word
  localparam logic [17:0]    PAT_DUAL      = 18'h330FC;  // two-lane test word
  // readout burst lengths in clock pulses
  localparam logic [3:0]     PULSES_SINGLE = 4'h9;
  localparam logic [3:0]     PULSES_DUAL   = 4'h5;
  localparam int             SHIFT_W       = 20;         // five pulses, two edges, two lanes
  // conversion timing
  localparam int             CLK_PERIOD_NS = 10;
  localparam int             CONV_MAX_NS   = 78;
  localparam int             CONV_CYCLES   = CONV_MAX_NS / CLK_PERIOD_NS;  // longest: round down
  localparam int             DET_LAT       = 3;          // strobe sync plus edge detect
  localparam logic [7:0]     CONV_RUN_LAST = 8'(CONV_CYCLES - DET_LAT - 1);
  localparam int             ACQ_NS        = 50;
  localparam int             RATE_MSPS     = 10;
  localparam int             MIN_CYCLE_NS  = 1000 / RATE_MSPS;
  localparam logic [7:0]     MIN_CYCLE_CYC = 8'((MIN_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // controller timing
  localparam logic [7:0]     STROBE_HIGH   = 8'h04;
  localparam logic [7:0]     CONV_WAIT     = 8'(CONV_CYCLES + 6);  // margin for device sync
  localparam logic [7:0]     HALF_PERIOD   = 8'h04;      // 80 ns readout clock
  localparam int             WAKE_MS       = 20;
  localparam int             WAKE_CYCLES   = WAKE_MS * 1000000 / CLK_PERIOD_NS;
  // first results after power-up or wake are junk
  localparam logic [1:0]     INVALID_CONV  = 2'h2;
  // result buffer
  localparam int             FIFO_DEPTH    = 16;
endpackage : sadc_pkg

/* File: shared/sadc_link_if.sv */
// Purpose: pins between converter and controller
// Assumes: all pins single-ended here; lvds pairs modelled as one wire
// Notes:   no two-way pins on this link
`timescale 1ns/100ps
interface sadc_link_if;
  logic convert_strobe;    // rising edge samples and converts
  logic sleep_n;           // low puts the converter to sleep
  logic dual_lane_select;  // high selects two data lanes
  logic pattern_force;     // high forces the test word
  logic readout_clk;       // burst clock from the controller
  logic echo_clock_out;    // readout clock echoed by the converter
  logic lane_a_out;        // data lane a
  logic lane_b_out;        // data lane b
  modport dev (input convert_strobe, sleep_n, dual_lane_select, pattern_force, readout_clk,
               output echo_clock_out, lane_a_out, lane_b_out);
  modport ctl (output convert_strobe, sleep_n, dual_lane_select, pattern_force, readout_clk,
               input echo_clock_out, lane_a_out, lane_b_out);
endinterface : sadc_link_if

/* File: hdl/sadc_fifo.sv */
// Purpose: result buffer between readout and the user side
// Assumes: single clock, synchronous reset
// Notes:   one spare pointer bit tells full from empty
`timescale 1ns/100ps
module sadc_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  // system
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];  // storage
  logic [AW:0]      wr_q;           // write pointer with wrap bit
  logic [AW:0]      rd_q;           // read pointer with wrap bit
  logic             full;
  logic             empty;

  // full when pointers differ only in the wrap bit
  assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty     = (wr_q == rd_q);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  // write side
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
    end else if (in_valid && !full) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
      wr_q                <= wr_q + 1'b1;
    end
  end

  // read side
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_q <= '0;
    end else if (out_ready && !empty) begin
      rd_q <= rd_q + 1'b1;
    end
  end
endmodule : sadc_fifo

/* File: hdl/sadc_device.sv */
// Purpose: converter end: conversion timing, sleep, test words, ddr readout
// Assumes: clk stands in for the self-timed conversion clock; rst is the supply reset
// Notes:   readout logic runs on the burst clock from the controller
// Operation
// [R1] strobe rising edge samples and starts conversion
// [R2] conversion done within 78 ns of strobe
// [R3] controller strobes at most 10 Msps
// [R4] controller keeps minimum strobe spacing
// [R5] first two results after wake are invalid
// [R6] sleep kills outputs and ignores strobes
// [R7] controller waits 20 ms after wake
// [R8] supply reset initialises the converter
// [R9] msb on lane a before first edge
// [R10] single lane needs nine readout pulses
// [R11] lane data advances on both clock edges
// [R12] readout clock echoed aligned with data
// [R13] controller reads before next conversion ends
// [R14] dual select enables lane b, bit pairs
// [R15] dual lane needs five readout pulses
// [R16] pattern force replaces results with test word
// [R17] fixed test words per lane mode
// [R18] eighteen bits, msb first
// [R19] lane a carries upper bit of pair
`timescale 1ns/100ps
module sadc_device (
  // system clock and supply reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // link to the controller
  sadc_link_if.dev                           link,
  // analog input, modelled as a ready-made word
  input  wire logic [sadc_pkg::RESULT_W-1:0] analog_in,
  // status toward the model user
  output logic                               converting,
  output logic                               results_valid,
  output logic      [sadc_pkg::RESULT_W-1:0] last_result
);
  import sadc_pkg::*;

  // next pulse count, wrapping at the burst length of the lane mode
  function automatic logic [3:0] next_pulse(input logic [3:0] cnt, input logic dual);
    logic [3:0] last;
    last = dual ? PULSES_DUAL - 4'h1 : PULSES_SINGLE - 4'h1;
    return (cnt == last) ? 4'h0 : cnt + 4'h1;
  endfunction : next_pulse

  // edges seen so far: equal counts mean an even number of edges
  function automatic logic [4:0] edge_index(input logic [3:0] pos, input logic [3:0] neg);
    return (pos != neg) ? {neg, 1'b1} : {pos, 1'b0};
  endfunction : edge_index

  // bit of the word at a position counted from the msb, zero past the end
  function automatic logic lane_bit(input logic [RESULT_W-1:0] word, input logic [4:0] pos);
    logic b;
    b = 1'b0;
    if (pos <= MSB_POS) begin
      b = word[MSB_POS - pos];
    end
    return b;
  endfunction : lane_bit

  // pin synchronisers, first stage read only by the second
  logic             cnv_s1_q;       // strobe stage one
  logic             cnv_s2_q;       // strobe stage two
  logic             cnv_s3_q;       // strobe edge memory
  logic             slp_s1_q;       // sleep stage one
  logic             slp_s2_q;       // sleep stage two, high = awake
  logic             dual_s1_q;      // lane select stage one
  logic             dual_s2_q;      // lane select stage two
  logic             pat_s1_q;       // pattern stage one
  logic             pat_s2_q;       // pattern stage two

  // conversion state
  logic                strobe_rise;   // one-cycle strobe edge
  logic                start;         // accepted conversion start
  logic                done;          // last cycle of a conversion
  logic                busy_q;        // conversion running
  logic [7:0]          run_cnt_q;     // cycles into the conversion
  logic [RESULT_W-1:0] sample_q;      // held input sample
  logic [RESULT_W-1:0] word_q;        // finished result
  logic [1:0]          warm_cnt_q;    // conversions since wake
  logic [RESULT_W-1:0] out_word;      // word presented to the lanes
  logic                link_rst_q;    // holds readout counters while asleep

  // readout clock domain
  logic [3:0]          pos_q;         // rising edges in this burst
  logic [3:0]          neg_q;         // falling edges in this burst
  logic [4:0]          idx;           // edges seen in this burst

  // synchronise the strobe, sleep, lane select and pattern pins into the clk domain
  always_ff @(posedge clk) begin
    if (rst) begin
      cnv_s1_q  <= 1'b0;
      cnv_s2_q  <= 1'b0;
      cnv_s3_q  <= 1'b0;
      slp_s1_q  <= 1'b0;
      slp_s2_q  <= 1'b0;
      dual_s1_q <= 1'b0;
      dual_s2_q <= 1'b0;
      pat_s1_q  <= 1'b0;
      pat_s2_q  <= 1'b0;
    end else begin
      cnv_s1_q  <= link.convert_strobe;
      cnv_s2_q  <= cnv_s1_q;
      cnv_s3_q  <= cnv_s2_q;
      slp_s1_q  <= link.sleep_n;
      slp_s2_q  <= slp_s1_q;
      dual_s1_q <= link.dual_lane_select;
      dual_s2_q <= dual_s1_q;
      pat_s1_q  <= link.pattern_force;
      pat_s2_q  <= pat_s1_q;
    end
  end

  // edge of the strobe; asleep or busy it is dropped
  assign strobe_rise = cnv_s2_q && !cnv_s3_q;  // [R1]
  assign start       = strobe_rise && slp_s2_q && !busy_q;  // [R6]
  assign done        = busy_q && (run_cnt_q == CONV_RUN_LAST);  // [R2]

  // conversion timer; sync latency is charged against the 78 ns budget
  always_ff @(posedge clk) begin
    if (rst || !slp_s2_q) begin  // [R8]
      busy_q    <= 1'b0;
      run_cnt_q <= 8'h00;
    end else if (start) begin  // [R1]
      busy_q    <= 1'b1;
      run_cnt_q <= 8'h00;
    end else if (busy_q) begin
      if (done) begin  // [R2]
        busy_q <= 1'b0;
      end
      run_cnt_q <= run_cnt_q + 8'h01;
    end
  end

  // sample held from the strobe edge to the end of conversion
  always_ff @(posedge clk) begin
    if (rst) begin
      sample_q <= '0;
    end else if (start) begin  // [R1]
      sample_q <= analog_in;
    end
  end

  // count the junk conversions after reset or wake
  always_ff @(posedge clk) begin
    if (rst || !slp_s2_q) begin  // [R5]
      warm_cnt_q <= 2'h0;
    end else if (done && (warm_cnt_q != INVALID_CONV)) begin
      warm_cnt_q <= warm_cnt_q + 2'h1;
    end
  end

  // result register; junk conversions deliver zero so they are easy to spot
  always_ff @(posedge clk) begin
    if (rst) begin  // [R8]
      word_q <= '0;
    end else if (done) begin
      word_q <= (warm_cnt_q == INVALID_CONV) ? sample_q : '0;  // [R5]
    end
  end

  // readout counters reset whenever asleep; the burst clock is idle then
  always_ff @(posedge clk) begin
    if (rst) begin
      link_rst_q <= 1'b1;
    end else begin
      link_rst_q <= !slp_s2_q;
    end
  end

  // test word overrides the result while forced
  always_comb begin
    out_word = word_q;
    if (pat_s2_q) begin  // [R16]
      out_word = dual_s2_q ? PAT_DUAL : PAT_SINGLE;  // [R17]
    end
  end

  // rising edges of the burst; word_q is stable during a legal readout
  always_ff @(posedge link.readout_clk or posedge link_rst_q) begin
    if (link_rst_q) begin
      pos_q <= 4'h0;
    end else begin
      pos_q <= next_pulse(pos_q, dual_s2_q);  // [R11]
    end
  end

  // falling edges of the burst
  always_ff @(negedge link.readout_clk or posedge link_rst_q) begin
    if (link_rst_q) begin
      neg_q <= 4'h0;
    end else begin
      neg_q <= next_pulse(neg_q, dual_s2_q);  // [R11]
    end
  end

  // bit pointer: index zero shows the msb before any edge
  assign idx = edge_index(pos_q, neg_q);  // [R9]

  // lane a carries the single stream or the upper bit of each pair
  always_comb begin
    link.lane_a_out = 1'b0;
    link.lane_b_out = 1'b0;
    if (slp_s2_q) begin  // [R6]
      if (dual_s2_q) begin  // [R14]
        link.lane_a_out = lane_bit(out_word, {idx[3:0], 1'b0});  // [R19]
        link.lane_b_out = lane_bit(out_word, {idx[3:0], 1'b1});  // [R19]
      end else begin
        link.lane_a_out = lane_bit(out_word, idx);  // [R18]
      end
    end
  end

  // echo follows the input clock through the same gating as the data
  assign link.echo_clock_out = link.readout_clk && slp_s2_q;  // [R12]

  // status
  assign converting    = busy_q;
  assign results_valid = slp_s2_q && (warm_cnt_q == INVALID_CONV);
  assign last_result   = word_q;
endmodule : sadc_device

/* File: hdl/sadc_host.sv */
// Purpose: controller end: strobe, readout burst, capture, discard, buffer
// Assumes: user inputs are synchronous to clk
// Notes:   the controller makes the readout clock by dividing clk
`timescale 1ns/100ps
module sadc_host #(
  parameter int WAKE_WAIT = sadc_pkg::WAKE_CYCLES
) (
  // system
  input  wire logic                          clk,
  input  wire logic                          rst,
  // link to the converter
  sadc_link_if.ctl                           link,
  // user control
  input  wire logic                          run,
  input  wire logic                          sleep_req,
  input  wire logic                          dual_mode,
  input  wire logic                          test_mode,
  output logic                               ready_to_use,
  output logic                               link_error,
  // result stream
  output logic                               m_valid,
  input  wire logic                          m_ready,
  output logic      [sadc_pkg::RESULT_W-1:0] m_data
);
  import sadc_pkg::*;

  typedef enum {ST_IDLE, ST_STROBE, ST_WAIT, ST_BURST, ST_PUSH, ST_SLEEP, ST_WAKE} sadc_host_st_type;

  sadc_host_st_type   st_q;        // controller state
  logic [7:0]         cnt_q;       // phase counter
  logic [7:0]         space_q;     // cycles since last strobe
  logic [31:0]        wake_q;      // wake settling counter
  logic [3:0]         pulse_q;     // pulses sent in this burst
  logic [1:0]         discard_q;   // results still to drop
  logic [SHIFT_W-1:0] shift_q;     // captured bits
  logic               cnv_q;       // strobe pin
  logic               sclk_q;      // readout clock pin
  logic               sleep_n_q;   // sleep pin
  logic               dual_q;      // lane select pin
  logic               pat_q;       // pattern pin
  logic               err_q;       // echo mismatch seen
  logic [1:0]         a_s, b_s, e_s;  // [0] first stage, [1] second stage
  logic [3:0]         pulses;
  logic               edge_now;    // last cycle of a half period
  logic               push;
  logic               push_ready;
  logic [RESULT_W-1:0] result;

  assign pulses   = dual_q ? PULSES_DUAL : PULSES_SINGLE;
  assign edge_now = (st_q == ST_BURST) && (cnt_q == HALF_PERIOD - 8'h01);
  assign result   = dual_q ? shift_q[SHIFT_W-1:2] : shift_q[RESULT_W-1:0];
  assign push     = (st_q == ST_PUSH) && (discard_q == 2'h0);

  // two stages on each returning pin
  always_ff @(posedge clk) begin
    if (rst) begin
      a_s <= 2'h0;
      b_s <= 2'h0;
      e_s <= 2'h0;
    end else begin
      a_s <= {a_s[0], link.lane_a_out};
      b_s <= {b_s[0], link.lane_b_out};
      e_s <= {e_s[0], link.echo_clock_out};
    end
  end

  // sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q    <= ST_IDLE;
      cnt_q   <= 8'h00;
      pulse_q <= 4'h0;
      wake_q  <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      case (st_q)
        ST_IDLE: begin
          cnt_q <= 8'h00;
          if (sleep_req) begin  // [R6]
            st_q <= ST_SLEEP;
          end else if (run && (space_q >= MIN_CYCLE_CYC)) begin  // [R3] [R4]
            st_q <= ST_STROBE;
          end
        end
        ST_STROBE: if (cnt_q == STROBE_HIGH - 8'h01) begin
          st_q  <= ST_WAIT;
          cnt_q <= 8'h00;
        end
        ST_WAIT: if (cnt_q == CONV_WAIT - 8'h01) begin  // [R13]
          st_q    <= ST_BURST;
          cnt_q   <= 8'h00;
          pulse_q <= 4'h0;
        end
        ST_BURST: if (edge_now) begin
          cnt_q <= 8'h00;
          if (sclk_q) begin
            pulse_q <= pulse_q + 4'h1;
            if (pulse_q == pulses - 4'h1) begin  // [R10] [R15]
              st_q <= ST_PUSH;
            end
          end
        end
        ST_PUSH: if (discard_q != 2'h0 || push_ready) begin
          st_q <= ST_IDLE;
        end
        ST_SLEEP: if (!sleep_req) begin
          st_q   <= ST_WAKE;
          wake_q <= 32'h0;
        end
        ST_WAKE: begin
          wake_q <= wake_q + 32'h1;
          if (wake_q >= 32'(WAKE_WAIT - 1)) begin  // [R7]
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // strobe spacing counter, restarted by each strobe
  always_ff @(posedge clk) begin
    if (rst || st_q == ST_STROBE) begin
      space_q <= 8'h00;
    end else if (space_q != 8'hFF) begin
      space_q <= space_q + 8'h01;
    end
  end

  // pins driven from flops
  always_ff @(posedge clk) begin
    if (rst) begin
      cnv_q     <= 1'b0;
      sleep_n_q <= 1'b1;
      dual_q    <= 1'b0;
      pat_q     <= 1'b0;
    end else begin
      cnv_q     <= (st_q == ST_IDLE) && run && !sleep_req && (space_q >= MIN_CYCLE_CYC)
                   || (st_q == ST_STROBE && cnt_q != STROBE_HIGH - 8'h01);
      sleep_n_q <= !(sleep_req && (st_q == ST_IDLE || st_q == ST_SLEEP));
      if (st_q == ST_IDLE) begin  // mode pins change only between conversions
        dual_q <= dual_mode;
        pat_q  <= test_mode;
      end
    end
  end

  // readout clock and capture: sample just before every edge
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_q  <= 1'b0;
      shift_q <= '0;
      err_q   <= 1'b0;
    end else if (edge_now) begin
      sclk_q <= !sclk_q;  // [R11]
      if (dual_q) begin
        shift_q <= {shift_q[SHIFT_W-3:0], a_s[1], b_s[1]};  // [R19]
      end else begin
        shift_q <= {shift_q[SHIFT_W-2:0], a_s[1]};  // [R18]
      end
      if (e_s[1] != sclk_q) begin  // [R12]
        err_q <= 1'b1;
      end
    end
  end

  // drop the junk results after reset and wake
  always_ff @(posedge clk) begin
    if (rst || st_q == ST_WAKE) begin
      discard_q <= INVALID_CONV;  // [R5]
    end else if (st_q == ST_PUSH && discard_q != 2'h0) begin
      discard_q <= discard_q - 2'h1;
    end
  end

  sadc_fifo #(
    .WIDTH (RESULT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (push_ready),
    .in_data   (result),
    .out_valid (m_valid),
    .out_ready (m_ready),
    .out_data  (m_data)
  );

  assign link.convert_strobe   = cnv_q;
  assign link.readout_clk      = sclk_q;
  assign link.sleep_n          = sleep_n_q;
  assign link.dual_lane_select = dual_q;
  assign link.pattern_force    = pat_q;
  assign ready_to_use          = (st_q != ST_SLEEP) && (st_q != ST_WAKE) && (discard_q == 2'h0);
  assign link_error            = err_q;
endmodule : sadc_host

/* File: verif/sadc_link_properties.sv */
// Purpose: link checks between converter and controller
// Assumes: link wires sampled on the system clock
// Notes:   a burst ends after 8 quiet cycles, longer than any half period
`timescale 1ns/100ps
module sadc_link_properties
  import sadc_pkg::*;
(
  // system
  input wire logic clk,
  input wire logic rst,
  // link wires
  input wire logic convert_strobe,
  input wire logic sleep_n,
  input wire logic dual_lane_select,
  input wire logic pattern_force,
  input wire logic readout_clk,
  input wire logic echo_clock_out,
  input wire logic lane_a_out,
  input wire logic lane_b_out
);
  logic [3:0] rises_q;  // readout pulses in this burst
  logic [3:0] idle_q;   // low cycles since the last pulse
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // quiet count, saturates so a long gap marks burst end
  always_ff @(posedge clk) begin
    if (rst) idle_q <= 4'h0;
    else if (readout_clk) idle_q <= 4'h0;
    else if (idle_q != 4'h8) idle_q <= idle_q + 4'h1;
  end
  // pulse count, cleared once the burst is over
  always_ff @(posedge clk) begin
    if (rst) rises_q <= 4'h0;
    else if ($rose(readout_clk)) rises_q <= rises_q + 4'h1;
    else if (idle_q == 4'h8) rises_q <= 4'h0;
  end
  AST_SLEEP_QUIET: assert property (!sleep_n [*4] |-> !lane_a_out && !lane_b_out && !echo_clock_out)
    else $error("outputs active while asleep");
  AST_ECHO_CLOCK: assert property (sleep_n [*4] |-> echo_clock_out == readout_clk)
    else $error("echo clock differs from readout clock");
  AST_LANE_B_OFF: assert property (!dual_lane_select [*4] |-> !lane_b_out)
    else $error("lane b active in single lane mode");
  AST_STROBE_SHAPE: assert property ($rose(convert_strobe) |-> convert_strobe [*4] ##1 !convert_strobe [*6])
    else $error("strobe width or spacing wrong");
  AST_HALF_PERIOD: assert property ($rose(readout_clk) |-> readout_clk [*4] ##1 !readout_clk)
    else $error("readout clock high time wrong");
  AST_BURST_LEN: assert property (
    idle_q == 4'h8 && rises_q != 4'h0 |-> rises_q == (dual_lane_select ? PULSES_DUAL : PULSES_SINGLE))
    else $error("readout burst has wrong pulse count");
  AST_MSB_FIRST: assert property (pattern_force && $rose(readout_clk) && rises_q == 4'h0 |->
    $past(lane_a_out) == (dual_lane_select ? PAT_DUAL[17] : PAT_SINGLE[17]))
    else $error("lane a lacks the top bit before the first edge");
  AST_PAIR_LOW: assert property (pattern_force && dual_lane_select && $rose(readout_clk) && rises_q == 4'h0 |->
    $past(lane_b_out) == PAT_DUAL[16])
    else $error("lane b lacks the second bit before the first edge");
endmodule : sadc_link_properties

/* File: verif/sadc_tb.sv */
// Purpose: end-to-end bench for converter and controller
// Assumes: host divides clk to make the readout clock
// Notes:   wake wait shortened; results judged on the host stream
`timescale 1ns/100ps
module sadc_tb;
  import sadc_pkg::*;
  localparam int          WAKE = 50;         // shortened wake wait
  localparam logic [17:0] A1   = 18'h2A5C3;  // first sample word
  localparam logic [17:0] A2   = 18'h1B3E4;  // second sample word
  logic        clk, rst, run, sleep_req, dual_mode, test_mode, m_ready;
  logic        converting, results_valid, ready_to_use, link_error, m_valid;
  logic [17:0] analog_in, last_result, m_data;
  int          n_errors, comparisons;
  sadc_link_if sadc_link_if_inst ();
  sadc_device sadc_device_inst (.clk(clk), .rst(rst), .link(sadc_link_if_inst.dev), .analog_in(analog_in),
    .converting(converting), .results_valid(results_valid), .last_result(last_result));
  sadc_host #(.WAKE_WAIT(WAKE)) sadc_host_inst (.clk(clk), .rst(rst), .link(sadc_link_if_inst.ctl), .run(run),
    .sleep_req(sleep_req), .dual_mode(dual_mode), .test_mode(test_mode), .ready_to_use(ready_to_use),
    .link_error(link_error), .m_valid(m_valid), .m_ready(m_ready), .m_data(m_data));
  sadc_link_properties sadc_link_properties_inst (.clk(clk), .rst(rst),
    .convert_strobe(sadc_link_if_inst.convert_strobe), .sleep_n(sadc_link_if_inst.sleep_n),
    .dual_lane_select(sadc_link_if_inst.dual_lane_select), .pattern_force(sadc_link_if_inst.pattern_force),
    .readout_clk(sadc_link_if_inst.readout_clk), .echo_clock_out(sadc_link_if_inst.echo_clock_out),
    .lane_a_out(sadc_link_if_inst.lane_a_out), .lane_b_out(sadc_link_if_inst.lane_b_out));
  // compare and count
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  // take one word off the stream, bounded wait
  task automatic get_word(output logic [17:0] w);
    int k;
    k = 0;
    while (m_valid !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    if (k == 3000) check(18'h0, 18'h1);
    w = m_data;
    m_ready = 1'b1;
    @(negedge clk);
    m_ready = 1'b0;
    @(negedge clk);  // let an edge pass before the next take
  endtask : get_word
  // modes latch only while idle, so stop and drain first
  task automatic set_mode(input logic d, input logic t, input logic [17:0] a);
    run = 1'b0;
    m_ready = 1'b1;
    repeat (400) @(negedge clk);
    m_ready = 1'b0;
    dual_mode = d;
    test_mode = t;
    analog_in = a;
    @(negedge clk);
    run = 1'b1;
  endtask : set_mode
  task automatic count_strobes(input int cycles, output int n);
    logic prev;
    n = 0;
    prev = sadc_link_if_inst.convert_strobe;
    repeat (cycles) begin
      @(negedge clk);
      if (!prev && sadc_link_if_inst.convert_strobe) n++;
      prev = sadc_link_if_inst.convert_strobe;
    end
  endtask : count_strobes
  // plain, dual and test words in both lane modes
  task automatic t_data();
    logic [17:0] w;
    logic [17:0] want [4];
    want = '{A1, A2, PAT_SINGLE, PAT_DUAL};
    for (int i = 0; i < 4; i++) begin
      set_mode(i[0], i[1], (i == 1) ? A2 : A1);
      repeat (2) begin
        get_word(w);
        check(w, want[i]);
      end
    end
    $display("test data done");
  endtask : t_data
  // busy must show and clear within 7 cycles of the strobe
  task automatic t_conv_time();
    logic busy;
    int   k;
    busy = 1'b0;
    k = 0;
    while (!(sadc_link_if_inst.convert_strobe === 1'b0) && k < 3000) begin
      @(negedge clk);
      k++;
    end
    while (sadc_link_if_inst.convert_strobe !== 1'b1 && k < 6000) begin
      @(negedge clk);
      k++;
    end
    for (k = 0; k < 12; k++) begin
      if (converting === 1'b1) busy = 1'b1;
      else if (busy) break;
      @(negedge clk);
    end
    check({17'h0, busy && k <= 7}, 18'h1);
    $display("test conversion time done");
  endtask : t_conv_time
  // full buffer must stop strobes, then hand back FIFO_DEPTH words
  task automatic t_fifo();
    logic [17:0] w;
    int          n;
    set_mode(1'b0, 1'b0, A1);
    repeat (3000) @(negedge clk);
    count_strobes(400, n);
    check(18'(n), 18'h0);
    run = 1'b0;
    repeat (FIFO_DEPTH) begin
      get_word(w);
      check(w, A1);
    end
    $display("test buffer done");
  endtask : t_fifo
  // sleep silences the link; two junk results after wake
  task automatic t_sleep();
    logic [17:0] w;
    int          n;
    int          m;
    m_ready = 1'b1;  // drain what the buffer test left behind
    repeat (400) @(negedge clk);
    m_ready = 1'b0;
    sleep_req = 1'b1;
    repeat (20) @(negedge clk);
    check(18'({sadc_link_if_inst.lane_a_out, sadc_link_if_inst.lane_b_out, sadc_link_if_inst.echo_clock_out,
      converting, results_valid, ready_to_use}), 18'h0);
    sleep_req = 1'b0;
    run = 1'b1;
    n = 0;
    repeat (40) begin
      if (results_valid !== 1'b1) begin
        count_strobes(10, m);
        n += m;
      end
    end
    check(18'(n), 18'h2);
    get_word(w);
    check(w, A1);
    check(last_result, A1);
    check({17'h0, ready_to_use}, 18'h1);
    check({17'h0, link_error}, 18'h0);
    $display("test sleep done");
  endtask : t_sleep
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watchdog, far beyond the expected run
  initial begin
    #400000;
    n_errors++;
    conclude();
  end
  initial begin
    {rst, run, sleep_req, dual_mode, test_mode, m_ready} = 6'h20;
    analog_in = A1;
    n_errors = 0;
    comparisons = 0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    t_data();
    t_conv_time();
    t_fifo();
    t_sleep();
    conclude();
  end
endmodule : sadc_tb
